/* i2chs_bus_master.sv */
// Bus controller model on the far side of the port's I2C pins.
// Assumes open-drain lines with pull-ups and a 1 ns time unit.
`timescale 1ns/10ps
module i2chs_bus_master (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic scl_low;
  logic sda_low;
  // A released line floats to its pull-up
  assign scl_in = !(scl_low || scl_oe);
  assign sda_in = !(sda_low || sda_oe);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // SCL stands still high outside frames
  task automatic start;
    sda_low = 1'b1;
    #40 scl_low = 1'b1;
    #20;
  endtask
  // 80 ns bit; waits while the target stretches SCL
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #20 scl_low = 1'b0;
    repeat (500) if (!scl_in) #4;
    #40 r = sda_in;
    scl_low = 1'b1;
    #20;
  endtask
  // Leaves SCL held low after the byte, an external hold
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic stop;
    sda_low = 1'b1;
    #20 scl_low = 1'b0;
    repeat (500) if (!scl_in) #4;
    #20 sda_low = 1'b0;
    #40;
  endtask
endmodule

/* i2chs_pkg.sv */
// Types shared by the port top and its SCL supervisor.
// Assumes i2chs_regs.svh supplies the numeric constants.
package i2chs_pkg;

  typedef enum logic [3:0] {
    I2CHS_IDLE, I2CHS_ADDR, I2CHS_ADDR2, I2CHS_ACK, I2CHS_RX,
    I2CHS_TX_LOAD, I2CHS_TX, I2CHS_TX_ACK, I2CHS_TX_ACKED
  } i2chs_state_type;

  typedef enum logic [1:0] {
    I2CHS_SV_IDLE, I2CHS_SV_HOLD, I2CHS_SV_WAIT, I2CHS_SV_HIGH
  } i2chs_sv_state_type;

  typedef struct packed {
    logic [7:0]      high_count;
    logic [7:0]      low_count;
    logic [15:0]     stall_limit_cycles;
    logic            rx_en;
    logic            tx_en;
    logic            ext_addr;
    logic [9:0]      own_addr;
    logic            enable;
    logic            hs_en;
    logic [4:0]      status;
    logic [4:0]      mask;
    logic [7:0]      rx_data;
    logic            rx_valid;
    logic [7:0]      tx_data;
    logic            tx_valid;
    logic [31:0]     prdata;
    logic            scl_m;
    logic            scl_s;
    logic            scl_d;
    logic            sda_m;
    logic            sda_s;
    logic            sda_d;
    i2chs_state_type state;
    i2chs_state_type ack_next;
    logic [7:0]      shift;
    logic [3:0]      bitcnt;
    logic            dir_read;
    logic            sda_drive;
    logic            stretch_req;
    logic [7:0]      div_cnt;
  } i2chs_main_type;

  typedef struct packed {
    i2chs_sv_state_type state;
    logic [15:0]        cnt;
    logic               timeout;
  } i2chs_sv_type;

endpackage

/* i2chs_port.sv */
// I2C peripheral port: APB registers, target engine, DMA requests, interrupt.
// Assumes scl_in and sda_in are raw pin levels and the pads are open drain.
//
// Contract
// - Eight-bit high count sets SCL high time after data placed, high-speed; here it only times the supervisor's high state, which drives no line.
// - Eight-bit low count sets how long SCL is held low after data placed.
// - Sixteen-bit stall limit, in I2C clock cycles, bounds a stalled SCL.
// - Timeout counting starts when our own logic releases SCL.
// - SCL not high within the limit raises a bus error.
// - On bus timeout both SCL and SDA are released.
// - Limit zero disables timeout; otherwise duration is limit I2C cycles.
// - Only our own SCL activity is timed, never an external hold.
// - Receive DMA enable bit gates receive DMA requests.
// - Transmit DMA enable bit gates transmit DMA requests.
// - Address length bit: zero 7-bit matching, one 10-bit matching.
// - Ten-bit own address field, set in peripheral mode, matched on bus.
// - Seven-bit address sits in the seven low bits of the field.
// - Ten-bit mode: upper nine bits address, low bit read/write.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "i2chs_regs.svh"
module i2chs_port #(
  parameter int I2C_CLK_DIV = `I2CHS_I2C_CLK_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             dma_rx_req,
  output logic             dma_tx_req,
  output logic             irq
);
  i2chs_pkg::i2chs_main_type r;
  i2chs_pkg::i2chs_main_type next_r;
  i2chs_stretch_if           sv_bus ();

  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic        tick;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        addr_hit;
  logic [4:0]  events;
  logic [31:0] rdata;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign mapped = (paddr == `I2CHS_CTRL_OFF)   || (paddr == `I2CHS_STATUS_OFF) ||
                  (paddr == `I2CHS_MASK_OFF)   || (paddr == `I2CHS_RXDATA_OFF) ||
                  (paddr == `I2CHS_TXDATA_OFF) || (paddr == `I2CHS_HSCLK_OFF)  ||
                  (paddr == `I2CHS_TIMEOUT_OFF) || (paddr == `I2CHS_DMA_OFF)   ||
                  (paddr == `I2CHS_ADDR0_OFF);

  // Edges compare the second sync stage with its one-cycle delay, the third stage
  assign scl_rise   = r.scl_s && !r.scl_d;
  assign scl_fall   = !r.scl_s && r.scl_d;
  assign start_cond = r.scl_s && r.scl_d && r.sda_d && !r.sda_s;
  assign stop_cond  = r.scl_s && r.scl_d && !r.sda_d && r.sda_s;
  assign tick       = (r.div_cnt == 8'(I2C_CLK_DIV - 1));

  // Read mux for the setup cycle; prdata is registered for the access phase
  always_comb begin
    rdata = 32'h0000_0000;
    if (paddr == `I2CHS_CTRL_OFF) begin
      rdata[`I2CHS_CTRL_EN_BIT] = r.enable;
      rdata[`I2CHS_CTRL_HS_BIT] = r.hs_en;
    end else if (paddr == `I2CHS_STATUS_OFF) begin
      rdata[4:0] = r.status;
    end else if (paddr == `I2CHS_MASK_OFF) begin
      rdata[4:0] = r.mask;
    end else if (paddr == `I2CHS_RXDATA_OFF) begin
      rdata[7:0] = r.rx_data;
    end else if (paddr == `I2CHS_TXDATA_OFF) begin
      rdata[7:0] = r.tx_data;
    end else if (paddr == `I2CHS_HSCLK_OFF) begin
      rdata[15:0] = {r.high_count, r.low_count};
    end else if (paddr == `I2CHS_TIMEOUT_OFF) begin
      rdata[15:0] = r.stall_limit_cycles;
    end else if (paddr == `I2CHS_DMA_OFF) begin
      rdata[`I2CHS_DMA_RX_BIT] = r.rx_en;
      rdata[`I2CHS_DMA_TX_BIT] = r.tx_en;
    end else if (paddr == `I2CHS_ADDR0_OFF) begin
      rdata[`I2CHS_EXT_ADDR_BIT] = r.ext_addr;
      rdata[9:0]                 = r.own_addr;
    end
  end

  // Own-address comparison for the first address byte
  always_comb begin
    if (r.ext_addr) begin
      // Ten-bit header carries the two top bits of the nine-bit address
      addr_hit = (r.shift[7:3] == `I2CHS_TEN_BIT_PREFIX) &&
                 (r.shift[2:1] == r.own_addr[9:8]);
    end else begin
      addr_hit = (r.shift[7:1] == r.own_addr[6:0]);
    end
  end

  always_comb begin
    next_r             = r;
    events             = 5'h00;
    next_r.stretch_req = 1'b0;
    next_r.div_cnt     = tick ? 8'h00 : r.div_cnt + 8'h01;
    next_r.scl_m       = scl_in;
    next_r.scl_s       = r.scl_m;
    next_r.scl_d       = r.scl_s;
    next_r.sda_m       = sda_in;
    next_r.sda_s       = r.sda_m;
    next_r.sda_d       = r.sda_s;

    if (setup) begin
      next_r.prdata = rdata;
    end

    // Bus engine
    if (!r.enable || sv_bus.timeout) begin
      next_r.state     = i2chs_pkg::I2CHS_IDLE;
      next_r.sda_drive = 1'b0;
    end else if (start_cond) begin
      next_r.state     = i2chs_pkg::I2CHS_ADDR;
      next_r.bitcnt    = 4'h0;
      next_r.sda_drive = 1'b0;
    end else if (stop_cond) begin
      next_r.state     = i2chs_pkg::I2CHS_IDLE;
      next_r.sda_drive = 1'b0;
      if (r.state != i2chs_pkg::I2CHS_IDLE) begin
        events[`I2CHS_EV_STOP] = 1'b1;
      end
    end else begin
      case (r.state)
        i2chs_pkg::I2CHS_ADDR, i2chs_pkg::I2CHS_ADDR2, i2chs_pkg::I2CHS_RX: begin
          if (scl_rise) begin
            next_r.shift  = {r.shift[6:0], r.sda_s};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == 4'h8) begin
            next_r.bitcnt    = 4'h0;
            next_r.sda_drive = 1'b1;
            next_r.state     = i2chs_pkg::I2CHS_ACK;
            if (r.state == i2chs_pkg::I2CHS_RX) begin
              next_r.rx_data       = r.shift;
              next_r.rx_valid      = 1'b1;
              events[`I2CHS_EV_RX] = 1'b1;
              next_r.ack_next      = i2chs_pkg::I2CHS_RX;
            end else if (r.state == i2chs_pkg::I2CHS_ADDR2) begin
              if (r.shift[7:1] == r.own_addr[7:1]) begin
                events[`I2CHS_EV_ADDR] = 1'b1;
                next_r.ack_next = r.dir_read ? i2chs_pkg::I2CHS_TX_LOAD
                                             : i2chs_pkg::I2CHS_RX;
              end else begin
                next_r.sda_drive = 1'b0;
                next_r.state     = i2chs_pkg::I2CHS_IDLE;
              end
            end else if (addr_hit) begin
              next_r.dir_read = r.shift[0];
              if (r.ext_addr) begin
                next_r.ack_next = i2chs_pkg::I2CHS_ADDR2;
              end else begin
                events[`I2CHS_EV_ADDR] = 1'b1;
                next_r.ack_next = r.shift[0] ? i2chs_pkg::I2CHS_TX_LOAD
                                             : i2chs_pkg::I2CHS_RX;
              end
            end else begin
              next_r.sda_drive = 1'b0;
              next_r.state     = i2chs_pkg::I2CHS_IDLE;
            end
          end
        end
        i2chs_pkg::I2CHS_ACK: begin
          if (scl_fall) begin
            next_r.sda_drive = 1'b0;
            next_r.state     = r.ack_next;
          end
        end
        i2chs_pkg::I2CHS_TX_LOAD: begin
          // An empty transmit register sends whatever byte was last loaded
          next_r.shift         = r.tx_data;
          next_r.tx_valid      = 1'b0;
          next_r.bitcnt        = 4'h0;
          next_r.sda_drive     = !r.tx_data[7];
          next_r.stretch_req   = r.hs_en;
          events[`I2CHS_EV_TX] = 1'b1;
          next_r.state         = i2chs_pkg::I2CHS_TX;
        end
        i2chs_pkg::I2CHS_TX: begin
          if (scl_rise) begin
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (r.bitcnt == 4'h8) begin
              next_r.sda_drive = 1'b0;
              next_r.state     = i2chs_pkg::I2CHS_TX_ACK;
            end else begin
              next_r.shift       = {r.shift[6:0], 1'b1};
              next_r.sda_drive   = !r.shift[6];
              next_r.stretch_req = r.hs_en;
            end
          end
        end
        i2chs_pkg::I2CHS_TX_ACK: begin
          if (scl_rise) begin
            next_r.state = r.sda_s ? i2chs_pkg::I2CHS_IDLE : i2chs_pkg::I2CHS_TX_ACKED;
          end
        end
        i2chs_pkg::I2CHS_TX_ACKED: begin
          if (scl_fall) begin
            next_r.state = i2chs_pkg::I2CHS_TX_LOAD;
          end
        end
        default: begin
          next_r.sda_drive = 1'b0;
        end
      endcase
    end

    events[`I2CHS_EV_TIMEOUT] = sv_bus.timeout;

    // Register writes take effect in the access phase
    if (wr) begin
      if (paddr == `I2CHS_CTRL_OFF) begin
        next_r.enable = pwdata[`I2CHS_CTRL_EN_BIT];
        next_r.hs_en  = pwdata[`I2CHS_CTRL_HS_BIT];
      end else if (paddr == `I2CHS_MASK_OFF) begin
        next_r.mask = pwdata[4:0];
      end else if (paddr == `I2CHS_TXDATA_OFF) begin
        next_r.tx_data  = pwdata[7:0];
        next_r.tx_valid = 1'b1;
      end else if (paddr == `I2CHS_HSCLK_OFF) begin
        next_r.high_count = pwdata[`I2CHS_HS_HIGH_LSB +: 8];
        next_r.low_count  = pwdata[`I2CHS_HS_LOW_LSB +: 8];
      end else if (paddr == `I2CHS_TIMEOUT_OFF) begin
        next_r.stall_limit_cycles = pwdata[15:0];
      end else if (paddr == `I2CHS_DMA_OFF) begin
        next_r.rx_en = pwdata[`I2CHS_DMA_RX_BIT];
        next_r.tx_en = pwdata[`I2CHS_DMA_TX_BIT];
      end else if (paddr == `I2CHS_ADDR0_OFF) begin
        next_r.ext_addr = pwdata[`I2CHS_EXT_ADDR_BIT];
        next_r.own_addr = pwdata[`I2CHS_ADDR_LSB +: 10];
      end
    end

    // Reading received data frees it, unless a new byte lands this cycle
    if (access && !pwrite && paddr == `I2CHS_RXDATA_OFF && !events[`I2CHS_EV_RX]) begin
      next_r.rx_valid = 1'b0;
    end

    // Write-one-to-clear; a new event in the same cycle wins
    if (wr && paddr == `I2CHS_STATUS_OFF) begin
      next_r.status = (r.status & ~pwdata[4:0]) | events;
    end else begin
      next_r.status = r.status | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r             <= '0;
      r.scl_m       <= 1'b1;
      r.scl_s       <= 1'b1;
      r.scl_d       <= 1'b1;
      r.sda_m       <= 1'b1;
      r.sda_s       <= 1'b1;
      r.sda_d       <= 1'b1;
      r.high_count  <= 8'(`I2CHS_RESET_VALUE);
      r.state       <= i2chs_pkg::I2CHS_IDLE;
      r.ack_next    <= i2chs_pkg::I2CHS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign sv_bus.tick       = tick;
  assign sv_bus.start      = r.stretch_req;
  assign sv_bus.low_count  = r.low_count;
  assign sv_bus.high_count = r.high_count;
  assign sv_bus.limit      = r.stall_limit_cycles;
  assign sv_bus.scl_high   = r.scl_s;

  i2chs_scl_supervisor u_sup (
    .pclk    (pclk),
    .presetn (presetn),
    .sv      (sv_bus)
  );

  assign prdata     = r.prdata;
  assign pready     = 1'b1;
  assign pslverr    = access && !mapped;
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  // Timeout releases both lines at once
  assign scl_oe     = sv_bus.hold_low && !sv_bus.timeout;
  assign sda_oe     = r.sda_drive && !sv_bus.timeout;
  assign dma_rx_req = r.rx_en && r.rx_valid;
  assign dma_tx_req = r.tx_en && !r.tx_valid;
  assign irq        = |(r.status & r.mask);
endmodule

/* i2chs_port_assertions.sv */
// Concurrent checks of the I2C port: DMA gating, SCL stretch and bus timeout.
// Assumes it is bound into i2chs_port and sees only that module's ports.
`timescale 1ns/10ps
module i2chs_port_assertions #(
  parameter int I2C_CLK_DIV = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        scl_in,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        dma_rx_req,
  input wire logic        dma_tx_req,
  input wire logic        irq
);
  logic        wr;
  logic        en;
  logic        ours;
  logic [4:0]  msk;
  logic [7:0]  low_cnt;
  logic [15:0] lim;
  logic [1:0]  dma;
  int          cnt;
  int          hcnt;
  int          low_ticks;
  int          tmo;
  assign wr        = psel && penable && pwrite;
  assign low_ticks = (low_cnt == 8'h00) ? 1 : int'(low_cnt);
  assign tmo = int'(lim) * I2C_CLK_DIV;
  // Shadows of software writes; ours marks a low SCL that we let go of
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {en, ours, msk, low_cnt, lim, dma} <= '0;
      cnt  <= 0;
      hcnt <= 0;
    end else begin
      if (wr && paddr == 12'h000) en <= pwdata[0];
      if (wr && paddr == 12'h008) msk <= pwdata[4:0];
      if (wr && paddr == 12'h03C) low_cnt <= pwdata[7:0];
      if (wr && paddr == 12'h040) lim <= pwdata[15:0];
      if (wr && paddr == 12'h048) dma <= pwdata[1:0];
      ours <= scl_oe || (ours && !scl_in);
      // An external hold that we never released is not counted
      cnt  <= (scl_oe || scl_in || !ours) ? 0 : cnt + 1;
      hcnt <= scl_oe ? hcnt + 1 : 0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rx_gate;
    dma_rx_req |-> dma[1];
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx dma while off");
  property p_tx_gate;
    dma_tx_req |-> dma[0];
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx dma while off");
  // Tick phase is unknown, so one tick of slack below
  property p_low_len;
    $fell(scl_oe) |-> hcnt >= (low_ticks - 1) * I2C_CLK_DIV &&
                      hcnt <= low_ticks * I2C_CLK_DIV + 1;
  endproperty
  a_low_len: assert property (p_low_len) else $error("stretch length");
  property p_not_early;
    $rose(irq) && msk == 5'h10 && ours |-> cnt >= tmo - I2C_CLK_DIV;
  endproperty
  a_not_early: assert property (p_not_early) else $error("early timeout");
  property p_expire;
    ours && lim != 16'h0 && msk[4] && cnt == tmo + 2 * I2C_CLK_DIV + 4 |-> irq;
  endproperty
  a_expire: assert property (p_expire) else $error("missed timeout");
  property p_release;
    ours && lim != 16'h0 && cnt > tmo + 2 * I2C_CLK_DIV + 4 |-> !sda_oe && !scl_oe;
  endproperty
  a_release: assert property (p_release) else $error("lines not released");
  property p_zero;
    lim == 16'h0 && msk == 5'h10 && cnt > 0 |-> !$rose(irq);
  endproperty
  a_zero: assert property (p_zero) else $error("timeout while disabled");
  property p_idle;
    !en && !$past(en) |-> !sda_oe && !scl_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("driving while disabled");
endmodule

bind i2chs_port i2chs_port_assertions #(.I2C_CLK_DIV(I2C_CLK_DIV)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .scl_in,
  .scl_oe, .sda_oe, .dma_rx_req, .dma_tx_req, .irq
);

/* i2chs_port_test.sv */
// Self-checking bench of the I2C port: registers, target transfers, timeout.
// Assumes the design, the bus master model and the checker are compiled first.
`timescale 1ns/10ps
module i2chs_port_test;
  localparam int DIV = 2;
  localparam logic [11:0] REGS [4] = '{12'h03C, 12'h040, 12'h048, 12'h04C};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_in;
  logic        scl_out;
  logic        sda_out;
  logic        scl_oe;
  logic        sda_in;
  logic        sda_oe;
  logic        dma_rx_req;
  logic        dma_tx_req;
  logic        irq;
  logic [31:0] seed;
  logic [31:0] r;
  logic        e;
  logic        ack;
  int          fail_count;
  int          compares;

  i2chs_port #(.I2C_CLK_DIV(DIV)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out,
    .sda_oe, .dma_rx_req, .dma_tx_req, .irq
  );
  i2chs_bus_master m (.scl_oe, .sda_oe, .scl_in, .sda_in);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] rmask(input logic [11:0] a);
    case (a)
      12'h048: return 32'h0000_0003;
      12'h04C: return 32'h0000_83FF;
      default: return 32'h0000_FFFF;
    endcase
  endfunction
  // First address byte; x spoils the match
  function automatic logic [7:0] first(input logic [9:0] a, input logic ten, input logic x);
    return ten ? {5'h1E, a[9:8] ^ {1'b0, x}, 1'b0} : {a[6:0] ^ {6'h0, x}, 1'b0};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        err;
    apb(1'b1, a, d, q, err);
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  initial begin
    logic [9:0] a;
    logic [7:0] b;
    logic       ten;
    logic       rxe;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    seed = 32'h0000_F75A;
    fail_count = 0;
    compares = 0;
    do_reset();
    foreach (REGS[i]) begin
      apb(1'b0, REGS[i], 32'h0, r, e);
      chk(r, 32'h0);
      repeat (3) begin
        wr(REGS[i], rnd());
        apb(1'b0, REGS[i], 32'h0, r, e);
        chk(r, seed & rmask(REGS[i]));
      end
      wr(REGS[i], 32'h0);
    end
    apb(1'b0, 12'h0F0, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1'b1);
    for (int k = 0; k < 3; k++) begin
      wr(k == 2 ? 12'h010 : 12'h048, 32'(k));
      settle();
      chk(dma_tx_req, k == 1);
    end
    for (int k = 0; k < 4; k++) begin
      ten = k[0];
      rxe = k[1];
      a   = 10'(rnd());
      b   = 8'(rnd());
      wr(12'h04C, {16'h0, ten, 5'h0, ten ? a : {3'h0, a[6:0]}});
      wr(12'h048, {30'h0, rxe, 1'b0});
      wr(12'h008, 32'h2);
      wr(12'h000, 32'h1);
      m.start();
      m.send(first(a, ten, 1'b1), ack);
      chk(ack, 1'b0);
      m.stop();
      m.start();
      m.send(first(a, ten, 1'b0), ack);
      chk(ack, 1'b1);
      if (ten) begin
        m.send({a[7:1], b[0]}, ack);
        chk(ack, 1'b1);
      end
      m.send(b, ack);
      m.stop();
      settle();
      chk(dma_rx_req, rxe);
      chk(irq, 1'b1);
      wr(12'h008, 32'h0);
      settle();
      chk(irq, 1'b0);
      apb(1'b0, 12'h00C, 32'h0, r, e);
      chk(r, {24'h0, b});
      settle();
      chk(dma_rx_req, 1'b0);
      wr(12'h004, 32'h1F);
      wr(12'h008, 32'h2);
      settle();
      chk(irq, 1'b0);
    end
    // Limit zero first, then a short limit; each after a fresh reset
    for (int j = 0; j < 2; j++) begin
      do_reset();
      wr(12'h000, 32'h3);
      wr(12'h03C, 32'h0000_0203);
      wr(12'h040, 32'(6 * j));
      wr(12'h008, 32'h10);
      wr(12'h04C, 32'h55);
      wr(12'h010, j ? 32'h0 : 32'hFF);
      m.start();
      m.send(8'hAB, ack);
      chk(ack, 1'b1);
      // Stall well past the limit so the checker sees the expiry window
      repeat (60) @(posedge pclk);
      chk(irq, j == 1);
      chk({scl_out, sda_out, scl_oe, sda_oe}, 4'h0);
      m.stop();
    end
    finish_test();
  end
endmodule

/* i2chs_regs.svh */
// Register offsets, field positions, reset values and timing counts of the port.
// Assumes a 12-bit APB byte address with one 32-bit word per register.
`ifndef I2CHS_REGS_SVH
`define I2CHS_REGS_SVH

`define I2CHS_ADDR_W          12
`define I2CHS_CTRL_OFF        12'h000
`define I2CHS_STATUS_OFF      12'h004
`define I2CHS_MASK_OFF        12'h008
`define I2CHS_RXDATA_OFF      12'h00C
`define I2CHS_TXDATA_OFF      12'h010
`define I2CHS_HSCLK_OFF       12'h03C
`define I2CHS_TIMEOUT_OFF     12'h040
`define I2CHS_DMA_OFF         12'h048
`define I2CHS_ADDR0_OFF       12'h04C

`define I2CHS_CTRL_EN_BIT     0
`define I2CHS_CTRL_HS_BIT     1
`define I2CHS_HS_HIGH_LSB     8
`define I2CHS_HS_LOW_LSB      0
`define I2CHS_DMA_RX_BIT      1
`define I2CHS_DMA_TX_BIT      0
`define I2CHS_EXT_ADDR_BIT    15
`define I2CHS_ADDR_LSB        0

`define I2CHS_EV_ADDR         0
`define I2CHS_EV_RX           1
`define I2CHS_EV_TX           2
`define I2CHS_EV_STOP         3
`define I2CHS_EV_TIMEOUT      4
`define I2CHS_EV_N            5

`define I2CHS_RESET_VALUE     32'h0000_0000
`define I2CHS_TEN_BIT_PREFIX  5'h1E
`define I2CHS_I2C_CLK_DIV     4

`endif

/* i2chs_scl_supervisor.sv */
// SCL stretch sequencer and bus timeout supervisor.
// Assumes tick is a one-cycle I2C clock enable and scl_high is synchronised.
`timescale 1ns/10ps
module i2chs_scl_supervisor (
  input  wire logic   pclk,
  input  wire logic   presetn,
  i2chs_stretch_if.sup sv
);
  i2chs_pkg::i2chs_sv_type r;
  i2chs_pkg::i2chs_sv_type next_r;

  always_comb begin
    next_r         = r;
    next_r.timeout = 1'b0;
    if (sv.start) begin
      // Driving SCL low again restarts everything
      next_r.state = i2chs_pkg::I2CHS_SV_HOLD;
      next_r.cnt   = 16'h0000;
    end else begin
      case (r.state)
        i2chs_pkg::I2CHS_SV_HOLD: begin
          if (sv.tick) begin
            if (r.cnt + 16'h0001 >= {8'h00, sv.low_count}) begin
              next_r.state = i2chs_pkg::I2CHS_SV_WAIT;
              next_r.cnt   = 16'h0000;
            end else begin
              next_r.cnt = r.cnt + 16'h0001;
            end
          end
        end
        i2chs_pkg::I2CHS_SV_WAIT: begin
          // Only our own release is timed, never an external hold
          if (sv.scl_high) begin
            next_r.state = i2chs_pkg::I2CHS_SV_HIGH;
            next_r.cnt   = 16'h0000;
          end else if (sv.tick && sv.limit != 16'h0000) begin
            if (r.cnt + 16'h0001 >= sv.limit) begin
              next_r.timeout = 1'b1;
              next_r.state   = i2chs_pkg::I2CHS_SV_IDLE;
              next_r.cnt     = 16'h0000;
            end else begin
              next_r.cnt = r.cnt + 16'h0001;
            end
          end
        end
        i2chs_pkg::I2CHS_SV_HIGH: begin
          if (sv.tick) begin
            if (r.cnt + 16'h0001 >= {8'h00, sv.high_count}) begin
              next_r.state = i2chs_pkg::I2CHS_SV_IDLE;
              next_r.cnt   = 16'h0000;
            end else begin
              next_r.cnt = r.cnt + 16'h0001;
            end
          end
        end
        default: begin
          next_r.cnt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state   <= i2chs_pkg::I2CHS_SV_IDLE;
      r.cnt     <= 16'h0000;
      r.timeout <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign sv.hold_low = (r.state == i2chs_pkg::I2CHS_SV_HOLD);
  assign sv.timeout  = r.timeout;
  assign sv.busy     = (r.state != i2chs_pkg::I2CHS_SV_IDLE);
endmodule

/* i2chs_stretch_if.sv */
// Bundle between the port top and its SCL supervisor.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface i2chs_stretch_if;
  logic        tick;
  logic        start;
  logic [7:0]  low_count;
  logic [7:0]  high_count;
  logic [15:0] limit;
  logic        scl_high;
  logic        hold_low;
  logic        timeout;
  logic        busy;

  modport ctrl (output tick, start, low_count, high_count, limit, scl_high,
                input hold_low, timeout, busy);
  modport sup  (input tick, start, low_count, high_count, limit, scl_high,
                output hold_low, timeout, busy);
endinterface
